/* File: verif/cpr_host.sv */
// host model: apb master issuing register transfers
`timescale 1ns/1ps
module cpr_host (
	input wire logic clk,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	output logic psel = 1'b0,
	output logic penable = 1'b0,
	output logic pwrite = 1'b0,
	output logic [11:0] paddr = 12'h0,
	output logic [31:0] pwdata = 32'h0,
	output logic hung = 1'b0
);
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		hung = (n >= 64);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

/* File: verif/cpr_props.sv */
// checker for the collision and page register slice
`timescale 1ns/1ps
module cpr_props
	import cpr_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_RSTN,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [3:0] I_PSTRB,
	input wire logic [31:0] O_PRDATA,
	input wire logic O_PSLVERR,
	input wire logic I_RX_BIT,
	input wire logic I_RX_BIT_VALID,
	input wire logic O_RX_BIT,
	input wire logic O_RX_BIT_VALID,
	input wire logic [CPR_ADDR_W-1:0] I_HOST_LATCH_ADDR,
	input wire logic [CPR_ADDR_W-1:0] O_REG_ADDR
);
	default clocking @(posedge I_CLK);
	endclocking
	default disable iff (!I_RSTN);
	logic [7:0] pg_q;
	wire acc = I_PSEL && I_PENABLE;
	wire hit = I_PADDR inside {CPR_OFS_COLL, CPR_OFS_PAGE, CPR_OFS_IRQ_STAT,
		CPR_OFS_IRQ_MASK, CPR_OFS_ADDR_CTL, CPR_OFS_ADDR_STAT};
	// shadow of the bank register so address forming can be judged from the ports
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			pg_q <= CPR_PAGE_RST;
		end else if (acc && I_PWRITE && I_PSTRB[0] && I_PADDR == CPR_OFS_PAGE) begin
			pg_q <= I_PWDATA[7:0] & 8'h83;
		end
	end
	a_unmapped_err: assert property (
		acc && !hit |-> O_PSLVERR && O_PRDATA == 32'h0) else $error("unmapped not refused");
	a_mapped_ok: assert property (
		acc && hit |-> !O_PSLVERR) else $error("mapped access refused");
	a_coll_rsv: assert property (
		acc && !I_PWRITE && I_PADDR == CPR_OFS_COLL |-> O_PRDATA[31:8] == 24'h0 && !O_PRDATA[6])
		else $error("collision reserved bits set");
	a_page_read: assert property (
		acc && !I_PWRITE && I_PADDR == CPR_OFS_PAGE |-> O_PRDATA == {24'h0, pg_q})
		else $error("bank register read wrong");
	a_addr_latch: assert property (
		!pg_q[CPR_OVR_BIT] |-> O_REG_ADDR == I_HOST_LATCH_ADDR) else $error("address not latch");
	a_addr_bank: assert property (
		pg_q[CPR_OVR_BIT] |-> O_REG_ADDR[5:4] == pg_q[1:0]) else $error("bank bits not used");
	a_rx_follow: assert property (
		O_RX_BIT_VALID == $past(I_RX_BIT_VALID)) else $error("rx valid latency wrong");
	a_rx_no_one: assert property (
		I_RX_BIT_VALID && !I_RX_BIT |=> !O_RX_BIT) else $error("rx bit invented");
endmodule
bind cpr_top cpr_props i_props (.*);

/* File: verif/cpr_top_tb.sv */
// testbench for the collision and page register slice
`timescale 1ns/1ps
module cpr_top_tb
	import cpr_pkg::*;
;
	logic clk = 1'b0, rstn = 1'b0, fs = 1'b0, bi = 1'b0, bv = 1'b0, co = 1'b0, fe = 1'b0;
	logic [5:0] pa = 6'h15, la = 6'h2a;
	wire psel, pen, pwr, rdy, err, orb, orv, irq, hung;
	wire [11:0] pad;
	wire [31:0] pwd, prd;
	wire [5:0] ra;
	int fails = 0, n_compared = 0, ones = 0;
	int cps[5] = '{1, 8, 32, 33, 0};
	logic [7:0] xp[5] = '{8'h81, 8'h88, 8'h80, 8'ha0, 8'ha0};
	logic [7:0] mk[5] = '{8'hff, 8'hff, 8'hff, 8'he0, 8'he0};
	logic [31:0] q;
	logic e;
	cpr_host i_host (.clk(clk), .pready(rdy), .prdata(prd), .pslverr(err), .psel(psel),
		.penable(pen), .pwrite(pwr), .paddr(pad), .pwdata(pwd), .hung(hung));
	cpr_top i_dut (.I_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(pad), .I_PWDATA(pwd), .I_PSTRB(4'hf), .O_PRDATA(prd),
		.O_PREADY(rdy), .O_PSLVERR(err), .I_RX_FRAME_START(fs), .I_RX_BIT(bi),
		.I_RX_BIT_VALID(bv), .I_RX_COLLISION(co), .I_RX_FRAME_END(fe), .O_RX_BIT(orb),
		.O_RX_BIT_VALID(orv), .I_HOST_PIN_ADDR(pa), .I_HOST_LATCH_ADDR(la),
		.O_REG_ADDR(ra), .O_IRQ(irq));
	initial forever #4 clk = ~clk;
	always @(posedge clk) if (orv === 1'b1 && orb === 1'b1) ones++;
	always @(posedge hung) begin
		fails++;
		wrap_up();
	end
	task automatic wrap_up();
		if (fails == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
		#1;
		n_compared++;
		if (x !== y) begin
			$display("wrong value %s expected %h seen %h", s, x, y);
			fails++;
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m = '1);
		i_host.xfer(1'b0, a, 32'h0, q, e);
		chk("read data", x, q & m);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_host.xfer(1'b1, a, d, q, e);
	endtask
	// last bit of each frame is a zero so dropped and kept bits both show
	task automatic frame(input int nb, input int cp);
		ones = 0;
		@(posedge clk);
		fs <= 1'b1;
		@(posedge clk);
		fs <= 1'b0;
		for (int i = 1; i <= nb; i++) begin
			bv <= 1'b1;
			bi <= (i != nb);
			co <= (i == cp);
			@(posedge clk);
		end
		bv <= 1'b0;
		co <= 1'b0;
		fe <= 1'b1;
		@(posedge clk);
		fe <= 1'b0;
		@(posedge clk);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(CPR_OFS_COLL, 32'ha0);
		rd(CPR_OFS_PAGE, 32'h0);
		rd(12'h020, 32'h0);
		chk("slverr", 32'h1, {31'h0, e});
		wr(CPR_OFS_COLL, 32'h7f);
		rd(CPR_OFS_COLL, 32'h20);
		wr(CPR_OFS_IRQ_MASK, 32'h3);
		frame(6, 3);
		chk("kept ones", 32'd2, ones);
		rd(CPR_OFS_COLL, 32'h03);
		chk("irq", 32'h1, {31'h0, irq});
		wr(CPR_OFS_IRQ_STAT, 32'h3);
		rd(CPR_OFS_IRQ_STAT, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		wr(CPR_OFS_COLL, 32'h80);
		for (int k = 0; k < 5; k++) begin
			frame(34, cps[k]);
			chk("kept ones", 32'd33, ones);
			rd(CPR_OFS_COLL, {24'h0, xp[k]}, {24'h0, mk[k]});
		end
		wr(CPR_OFS_IRQ_MASK, 32'h0);
		wr(CPR_OFS_IRQ_STAT, 32'h3);
		frame(2, 0);
		rd(CPR_OFS_IRQ_STAT, 32'h1);
		chk("irq", 32'h0, {31'h0, irq});
		wr(CPR_OFS_PAGE, 32'hff);
		rd(CPR_OFS_PAGE, 32'h83);
		chk("addr", 32'h3a, 32'(ra));
		wr(CPR_OFS_ADDR_CTL, 32'h1);
		rd(CPR_OFS_ADDR_STAT, 32'h35);
		chk("addr", 32'h35, 32'(ra));
		wr(CPR_OFS_PAGE, 32'h03);
		rd(CPR_OFS_ADDR_STAT, 32'h2a);
		chk("addr", 32'h2a, 32'(ra));
		wrap_up();
	end
endmodule

/* File: verilog/cpr_addr_map.sv */
// register address former: bank number overrides upper address bits
`timescale 1ns/1ps
module cpr_addr_map
	import cpr_pkg::*;
(
	input wire logic override_en,
	input wire logic [1:0] bank,
	input wire logic use_pins,
	input wire logic [CPR_ADDR_W-1:0] pin_addr,
	input wire logic [CPR_ADDR_W-1:0] latch_addr,
	output logic [CPR_ADDR_W-1:0] reg_addr
);
	logic [3:0] low;

	always_comb begin
		low = use_pins ? pin_addr[3:0] : latch_addr[3:0]; // [R9]
		if (override_en) begin
			reg_addr = {bank, low}; // [R8] [R11]
		end else begin
			reg_addr = latch_addr; // [R10]
		end
	end
endmodule

/* File: verilog/cpr_coll_track.sv */
// first-collision tracker: counts data bits and latches the first collision
`timescale 1ns/1ps
module cpr_coll_track
	import cpr_pkg::*;
#(
	parameter int MAX_POS = 32
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic frame_start,
	input wire logic data_bit,
	input wire logic data_val,
	input wire logic coll,
	input wire logic frame_end,
	input wire logic keep_after,
	output logic [CPR_IDX_W-1:0] idx_q,
	output logic invalid_q,
	output logic bit_out,
	output logic bit_out_val,
	output logic coll_seen
);
	if (MAX_POS != 32) begin : g_bad_pos
		$error("index field holds exactly 32 positions");
	end

	logic [6:0] cnt_q;
	logic hit_q;
	logic [6:0] hit_pos_q;
	logic [6:0] cnt_inc;
	logic first_coll;

	assign cnt_inc = cnt_q + 7'h01;
	assign first_coll = data_val && coll && !hit_q;
	assign coll_seen = hit_q;

	// only data bits arrive with data_val; framing and parity never strobe it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 7'h00;
		end else if (frame_start) begin
			cnt_q <= 7'h00;
		end else if (data_val && cnt_q != 7'h7f) begin
			cnt_q <= cnt_inc; // [R4]
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hit_q <= 1'b0;
			hit_pos_q <= 7'h00;
		end else if (frame_start) begin
			hit_q <= 1'b0;
		end else if (first_coll) begin
			hit_q <= 1'b1;
			// past the counter's end the position must read invalid, not wrap to bit 32
			hit_pos_q <= (cnt_q == 7'h7f) ? 7'h7f : cnt_inc; // [R4] [R3]
		end
	end

	// position 32 wraps to 00h naturally by truncation to five bits
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			idx_q <= 5'h00;
			invalid_q <= 1'b1; // [R7]
		end else if (frame_end) begin
			idx_q <= hit_pos_q[CPR_IDX_W-1:0]; // [R5] [R14]
			invalid_q <= !hit_q || hit_pos_q > 7'd32; // [R3] [R14]
		end
	end

	// collided bit itself and everything after it is zeroed unless kept
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bit_out <= 1'b0;
			bit_out_val <= 1'b0;
		end else begin
			bit_out_val <= data_val;
			bit_out <= data_bit && (keep_after || !(hit_q || first_coll)); // [R1]
		end
	end
endmodule

/* File: verilog/cpr_pkg.sv */
// constants and field layout of the collision and page register slice
//
// Overview of operation
// R1 - keep bit 0 clears every received bit after a collision; 1 keeps them
// R2 - host clears keep bit only for bitwise anticollision at 106 kbit
// R3 - invalid flag set when no collision or position beyond index range
// R4 - 5-bit index records first collision, counting data bits only
// R5 - index is one-based; 01h first bit, 08h eighth, 00h thirty-second
// R6 - host uses index only in 106 kbit modes and when flag is 0
// R7 - collision register resets to 101XXXXXb
// R8 - bank override on: address bits A5 and A4 come from bank number
// R9 - bank override on: low address bits come from pins or latch
// R10 - bank override off: whole address from internal latch
// R11 - bank number selects page only while override enabled
// R12 - page-select register resets to all zeros
// R13 - reserved bits read 0; index and flag read-only, keep bit writable
// R14 - index and flag update at end of each reception
package cpr_pkg;
	// register indices are word numbers; each byte address is four times its index
	localparam logic [9:0] CPR_IDX_COLL = 10'h00e;
	localparam logic [9:0] CPR_IDX_PAGE = 10'h010;
	localparam logic [9:0] CPR_IDX_IRQ_STAT = 10'h020;
	localparam logic [9:0] CPR_IDX_IRQ_MASK = 10'h021;
	localparam logic [9:0] CPR_IDX_ADDR_CTL = 10'h022;
	localparam logic [9:0] CPR_IDX_ADDR_STAT = 10'h023;
	localparam logic [11:0] CPR_OFS_COLL = {CPR_IDX_COLL, 2'b00};
	localparam logic [11:0] CPR_OFS_PAGE = {CPR_IDX_PAGE, 2'b00};
	localparam logic [11:0] CPR_OFS_IRQ_STAT = {CPR_IDX_IRQ_STAT, 2'b00};
	localparam logic [11:0] CPR_OFS_IRQ_MASK = {CPR_IDX_IRQ_MASK, 2'b00};
	localparam logic [11:0] CPR_OFS_ADDR_CTL = {CPR_IDX_ADDR_CTL, 2'b00};
	localparam logic [11:0] CPR_OFS_ADDR_STAT = {CPR_IDX_ADDR_STAT, 2'b00};
	localparam int CPR_KEEP_BIT = 7;
	localparam int CPR_INVALID_BIT = 5;
	localparam int CPR_OVR_BIT = 7;
	localparam logic [7:0] CPR_COLL_RST = 8'ha0;
	localparam logic [7:0] CPR_PAGE_RST = 8'h00;
	localparam int CPR_IDX_W = 5;
	localparam int CPR_ADDR_W = 6;
	localparam int CPR_NUM_IRQ = 2;
	localparam int CPR_IRQ_FRAME = 0;
	localparam int CPR_IRQ_COLL = 1;
	localparam logic [2:0] CPR_IRQ_RST = 3'h0;
endpackage

/* File: verilog/cpr_top.sv */
// apb register slice: first-collision status, bank choice and interrupts
`timescale 1ns/1ps
module cpr_top
	import cpr_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_RSTN,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [3:0] I_PSTRB,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic I_RX_FRAME_START,
	input wire logic I_RX_BIT,
	input wire logic I_RX_BIT_VALID,
	input wire logic I_RX_COLLISION,
	input wire logic I_RX_FRAME_END,
	output logic O_RX_BIT,
	output logic O_RX_BIT_VALID,
	input wire logic [CPR_ADDR_W-1:0] I_HOST_PIN_ADDR,
	input wire logic [CPR_ADDR_W-1:0] I_HOST_LATCH_ADDR,
	output logic [CPR_ADDR_W-1:0] O_REG_ADDR,
	output logic O_IRQ
);
	logic keep_q;
	logic ovr_q;
	logic [1:0] bank_q;
	logic use_pins_q;
	logic [CPR_NUM_IRQ-1:0] irq_stat_q;
	logic [CPR_NUM_IRQ-1:0] irq_mask_q;
	logic [CPR_IDX_W-1:0] idx;
	logic invalid;
	logic coll_seen;
	logic wr;
	logic rd;
	logic lane0;
	logic mapped;
	logic [31:0] rdata_d;
	logic [CPR_NUM_IRQ-1:0] irq_evt;
	logic [CPR_NUM_IRQ-1:0] irq_clr;

	// single-cycle answer: the access phase always completes at once
	assign O_PREADY = 1'b1;
	assign wr = I_PSEL && I_PENABLE && I_PWRITE;
	assign rd = I_PSEL && I_PENABLE && !I_PWRITE;
	assign lane0 = I_PSTRB[0];

	always_comb begin
		mapped = 1'b1;
		case (I_PADDR)
			CPR_OFS_COLL: rdata_d = {24'h0, keep_q, 1'b0, invalid, idx}; // [R13]
			CPR_OFS_PAGE: rdata_d = {24'h0, ovr_q, 5'h00, bank_q}; // [R13]
			CPR_OFS_IRQ_STAT: rdata_d = {30'h0, irq_stat_q};
			CPR_OFS_IRQ_MASK: rdata_d = {30'h0, irq_mask_q};
			CPR_OFS_ADDR_CTL: rdata_d = {31'h0, use_pins_q};
			CPR_OFS_ADDR_STAT: rdata_d = {26'h0, O_REG_ADDR};
			default: begin
				rdata_d = 32'h0;
				mapped = 1'b0;
			end
		endcase
	end

	// unmapped addresses answer with an error and read as zero
	assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;
	assign O_PRDATA = rd ? rdata_d : 32'h0;

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			keep_q <= CPR_COLL_RST[CPR_KEEP_BIT]; // [R7]
		end else if (wr && lane0 && I_PADDR == CPR_OFS_COLL) begin
			keep_q <= I_PWDATA[CPR_KEEP_BIT]; // [R13]
		end
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ovr_q <= CPR_PAGE_RST[CPR_OVR_BIT]; // [R12]
			bank_q <= CPR_PAGE_RST[1:0]; // [R12]
		end else if (wr && lane0 && I_PADDR == CPR_OFS_PAGE) begin
			ovr_q <= I_PWDATA[CPR_OVR_BIT];
			bank_q <= I_PWDATA[1:0];
		end
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			use_pins_q <= 1'b0;
		end else if (wr && lane0 && I_PADDR == CPR_OFS_ADDR_CTL) begin
			use_pins_q <= I_PWDATA[0];
		end
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			irq_mask_q <= CPR_IRQ_RST[CPR_NUM_IRQ-1:0];
		end else if (wr && lane0 && I_PADDR == CPR_OFS_IRQ_MASK) begin
			irq_mask_q <= I_PWDATA[CPR_NUM_IRQ-1:0];
		end
	end

	assign irq_clr = (wr && lane0 && I_PADDR == CPR_OFS_IRQ_STAT) ?
		I_PWDATA[CPR_NUM_IRQ-1:0] : '0;
	assign irq_evt[CPR_IRQ_FRAME] = I_RX_FRAME_END;
	assign irq_evt[CPR_IRQ_COLL] = I_RX_FRAME_END && coll_seen;

	// a new event beats a simultaneous write-one clear
	genvar g;
	generate
		for (g = 0; g < CPR_NUM_IRQ; g++) begin : g_irq
			always_ff @(posedge I_CLK or negedge I_RSTN) begin
				if (!I_RSTN) begin
					irq_stat_q[g] <= 1'b0;
				end else if (irq_evt[g]) begin
					irq_stat_q[g] <= 1'b1;
				end else if (irq_clr[g]) begin
					irq_stat_q[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_IRQ <= 1'b0;
		end else begin
			O_IRQ <= |(irq_stat_q & irq_mask_q);
		end
	end

	// receive strobes come from same-clock logic, so no synchroniser
	cpr_coll_track #(
		.MAX_POS(32)
	) u_track (
		.clk(I_CLK),
		.rstn(I_RSTN),
		.frame_start(I_RX_FRAME_START),
		.data_bit(I_RX_BIT),
		.data_val(I_RX_BIT_VALID),
		.coll(I_RX_COLLISION),
		.frame_end(I_RX_FRAME_END),
		.keep_after(keep_q), // [R1]
		.idx_q(idx),
		.invalid_q(invalid),
		.bit_out(O_RX_BIT),
		.bit_out_val(O_RX_BIT_VALID),
		.coll_seen(coll_seen)
	);

	cpr_addr_map u_map (
		.override_en(ovr_q), // [R8]
		.bank(bank_q),
		.use_pins(use_pins_q),
		.pin_addr(I_HOST_PIN_ADDR),
		.latch_addr(I_HOST_LATCH_ADDR),
		.reg_addr(O_REG_ADDR)
	);
endmodule
